// ---- design/hdb_defs.svh ----
/*
 * Register offsets, field positions, reset values and address map of the
 * host shared access bridge.
 * Assumes a 6-bit register address on a plain strobe port.
 */
`ifndef HDB_DEFS_SVH
`define HDB_DEFS_SVH
// ==========================================================================
// Register offsets
`define HDB_RA_CTRL    6'h00
`define HDB_RA_CFG     6'h04
`define HDB_RA_DADDR   6'h08
`define HDB_RA_DDATA   6'h0c
`define HDB_RA_DFLAG   6'h10
`define HDB_RA_STAT    6'h14
// ==========================================================================
// Control register fields
`define HDB_CTL_PRIO   1:0
`define HDB_CTL_BSW_WR 2
`define HDB_CTL_HSW_WR 3
`define HDB_CTL_BSW_RD 4
`define HDB_CTL_HSW_RD 5
`define HDB_CTL_FACT   11:8
`define HDB_CTL_TMO    24:16
`define HDB_CTL_RST    32'h0000_0100
`define HDB_TMO_MAX    9'h100
`define HDB_SIZE_RST   16'hffff
// ==========================================================================
// Access sizes and address map
`define HDB_SZ_BYTE    2'h0
`define HDB_SZ_HALF    2'h1
`define HDB_SZ_WORD    2'h2
`define HDB_PER_BIT    23
`define HDB_PRV_BIT    22
`define HDB_EXT_BIT    22
`define HDB_DUAL_TOP   24'h00ffff
`define HDB_HALF_STEP  24'h000002
// ==========================================================================
// Debug flag fields
`define HDB_FL_TMO     0
`define HDB_FL_DSP     1
`define HDB_FL_SIZE    2
`define HDB_FL_MODE    3
`define HDB_FL_PRIV    4
`endif

// ---- design/hdb_pkg.sv ----
/*
 * Types of the host shared access bridge: states, targets, state record.
 * Assumes the constants header is included by the design module.
 */
package hdb_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_HIGH = 3'b010,
    S_LOW  = 3'b011,
    S_DONE = 3'b100
  } hdb_state_t;

  typedef enum logic [2:0] {
    T_SNGL  = 3'b000,
    T_DUAL  = 3'b001,
    T_EXT   = 3'b010,
    T_SHPER = 3'b011,
    T_PRPER = 3'b100
  } hdb_tgt_t;

  typedef struct packed {
    hdb_state_t  state;
    logic [31:0] ctrl;
    logic [15:0] cfg_pend;
    logic [15:0] cfg_eff;
    logic [23:0] dbg_addr;
    logic [31:0] dbg_data;
    logic [7:0]  dbg_flag;
    logic [31:0] reg_rdata;
    logic [1:0]  ini;
    logic        we;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [31:0] wraw;
    logic [31:0] wdata;
    hdb_tgt_t    tgt;
    logic        second;
    logic [3:0]  cnt;
    logic [8:0]  tmo;
    logic        tmo_en;
    logic [15:0] rbuf;
    logic [31:0] rdata;
    logic [2:0]  done;
    logic [2:0]  err;
    logic [23:0] dsp_addr;
    logic [15:0] dsp_wdata;
    logic [1:0]  be;
    logic        dsp_we;
    logic        strobe_n;
    logic        resync;
  } hdb_st_t;
endpackage

// ---- design/hdb_bridge.sv ----
/*
 * Host side bridge: three host initiators share one 16-bit strobed port
 * into the DSP subsystem, with swapping, strobe stretching, mode checks,
 * time-out and debug capture.
 * Assumes initiators hold their request until done, and that the DSP side
 * supplies mode selections, conflict busy, ready and error answers.
 */
`timescale 1ns/1ps
`include "hdb_defs.svh"
module hdb_bridge (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [5:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic [2:0]        ini_req_i,
  input  wire logic [2:0]        ini_we_i,
  input  wire logic [2:0][1:0]   ini_size_i,
  input  wire logic [2:0][23:0]  ini_addr_i,
  input  wire logic [2:0][31:0]  ini_wdata_i,
  output logic      [2:0]        ini_done_o,
  output logic      [2:0]        ini_err_o,
  output logic      [31:0]       ini_rdata_o,
  input  wire logic              dsp_rst_release_i,
  input  wire logic              mem_shared_i,
  input  wire logic              per_shared_i,
  output logic      [23:0]       dsp_addr_o,
  output logic      [15:0]       dsp_wdata_o,
  output logic      [1:0]        dsp_be_o,
  output logic                   dsp_we_o,
  output logic                   dsp_strobe_n_o,
  output logic                   dsp_resync_o,
  input  wire logic [15:0]       dsp_rdata_i,
  input  wire logic              dsp_ready_i,
  input  wire logic              dsp_busy_i,
  input  wire logic              dsp_tmo_err_i,
  input  wire logic              dsp_size_err_i,
  input  wire logic [23:0]       dsp_sa_addr_i,
  output logic                   dsp_sa_deny_o,
  output logic                   mem_host_only_o,
  output logic                   per_host_only_o
);
  // ========================================================================
  // Helpers
  function automatic logic [1:0] arb_pick(input logic [2:0] r,
                                          input logic [1:0] p);
    logic [1:0] s;
    logic [1:0] k;
    arb_pick = 2'h0;
    s = (p == 2'h3) ? 2'h0 : p;
    for (int j = 2; j >= 0; j--) begin
      k = 2'((32'(s) + 32'(j)) % 32'd3);
      if (r[k]) arb_pick = k;
    end
  endfunction

  function automatic hdb_pkg::hdb_tgt_t decode(input logic [23:0] a);
    if (a[`HDB_PER_BIT])
      decode = a[`HDB_PRV_BIT] ? hdb_pkg::T_PRPER : hdb_pkg::T_SHPER;
    else if (a[`HDB_EXT_BIT])
      decode = hdb_pkg::T_EXT;
    else if (a <= `HDB_DUAL_TOP)
      decode = hdb_pkg::T_DUAL;
    else
      decode = hdb_pkg::T_SNGL;
  endfunction

  // Same function serves both directions since both swaps are involutions.
  function automatic logic [31:0] swap(input logic [31:0] v,
                                       input logic bs, input logic hs,
                                       input logic [1:0] sz);
    logic [31:0] t;
    t = v;
    if (sz == `HDB_SZ_WORD) begin
      if (bs) t = {v[7:0], v[15:8], v[23:16], v[31:24]};
      if (hs) t = {t[15:0], t[31:16]};
    end else if (sz == `HDB_SZ_HALF) begin
      t = bs ? {16'h0, v[7:0], v[15:8]} : {16'h0, v[15:0]};
    end else begin
      t = {16'h0, v[7:0], v[7:0]};
    end
    swap = t;
  endfunction

  // ========================================================================
  // Mode and arbitration
  hdb_pkg::hdb_st_t  q;
  hdb_pkg::hdb_st_t  d;
  logic              mem_ho;
  logic              per_ho;
  logic [1:0]        arb_i;
  hdb_pkg::hdb_tgt_t arb_tgt;
  logic [3:0]        nf;
  logic [8:0]        tmo_ld;
  logic [31:0]       rd_asm;

  assign mem_ho = !dsp_rst_release_i || !mem_shared_i;
  assign per_ho = !dsp_rst_release_i || !per_shared_i;
  assign arb_i = arb_pick(ini_req_i, q.ctrl[`HDB_CTL_PRIO]);
  assign arb_tgt = decode(ini_addr_i[arb_i]);
  assign nf = (q.ctrl[`HDB_CTL_FACT] == 4'h0) ? 4'h1
                                              : q.ctrl[`HDB_CTL_FACT];
  assign tmo_ld = (q.ctrl[`HDB_CTL_TMO] > `HDB_TMO_MAX) ? `HDB_TMO_MAX
                                                        : q.ctrl[`HDB_CTL_TMO];
  // The exclusive region is compared wide because size times 8K spans 29 bits.
  assign dsp_sa_deny_o = mem_ho ?
    ({5'h0, dsp_sa_addr_i} < {q.cfg_eff, 13'h0}) :
    (q.cfg_eff == `HDB_SIZE_RST);

  always_comb begin
    case (q.size)
      `HDB_SZ_WORD: rd_asm = {dsp_rdata_i, q.rbuf};
      `HDB_SZ_HALF: rd_asm = {16'h0, dsp_rdata_i};
      default: rd_asm = {24'h0, q.addr[0] ? dsp_rdata_i[15:8]
                                          : dsp_rdata_i[7:0]};
    endcase
  end

  // ========================================================================
  // Next state
  logic        fail;
  logic [4:0]  cause;
  logic [23:0] fa;
  logic        fw;
  logic [31:0] fwv;
  logic [1:0]  fi;
  logic        run;

  always_comb begin
    d = q;
    fail = 1'b0;
    cause = 5'h0;
    fa = q.addr;
    fw = q.we;
    fwv = q.wraw;
    fi = q.ini;
    run = 1'b0;
    d.done = 3'h0;
    d.err = 3'h0;
    d.reg_rdata = 32'h0;
    if (reg_re_i) begin
      case (reg_addr_i)
        `HDB_RA_CTRL:  d.reg_rdata = q.ctrl;
        `HDB_RA_CFG:   d.reg_rdata = {16'h0, q.cfg_pend};
        `HDB_RA_DADDR: d.reg_rdata = {8'h0, q.dbg_addr};
        `HDB_RA_DDATA: d.reg_rdata = q.dbg_data;
        `HDB_RA_DFLAG: d.reg_rdata = {24'h0, q.dbg_flag};
        `HDB_RA_STAT:  d.reg_rdata = {29'h0, mem_ho, per_ho,
                                      q.state != hdb_pkg::S_IDLE};
        default:       d.reg_rdata = 32'h0;
      endcase
    end
    if (reg_we_i) begin
      case (reg_addr_i)
        `HDB_RA_CTRL:  d.ctrl = reg_wdata_i;
        `HDB_RA_CFG:   d.cfg_pend = reg_wdata_i[15:0];
        `HDB_RA_DFLAG: d.dbg_flag = 8'h0;
        default: ;
      endcase
    end
    if (!dsp_rst_release_i) d.cfg_eff = q.cfg_pend;
    case (q.state)
      hdb_pkg::S_IDLE: begin
        if (|ini_req_i) begin
          d.ini = arb_i;
          d.we = ini_we_i[arb_i];
          d.size = ini_size_i[arb_i];
          d.addr = ini_addr_i[arb_i];
          d.wraw = ini_wdata_i[arb_i];
          d.wdata = swap(ini_wdata_i[arb_i], q.ctrl[`HDB_CTL_BSW_WR],
                         q.ctrl[`HDB_CTL_HSW_WR], ini_size_i[arb_i]);
          d.tgt = arb_tgt;
          d.second = 1'b0;
          d.resync = (arb_tgt == hdb_pkg::T_SHPER) ? !per_ho : !mem_ho;
          d.tmo_en = (arb_tgt == hdb_pkg::T_SHPER) && per_ho &&
                     (tmo_ld != 9'h0);
          fi = arb_i;
          fa = ini_addr_i[arb_i];
          fw = ini_we_i[arb_i];
          fwv = ini_wdata_i[arb_i];
          if (mem_ho && (arb_tgt == hdb_pkg::T_DUAL ||
                         arb_tgt == hdb_pkg::T_EXT)) begin
            fail = 1'b1;
            cause[`HDB_FL_MODE] = 1'b1;
          end else if (arb_tgt == hdb_pkg::T_PRPER) begin
            fail = 1'b1;
            cause[`HDB_FL_PRIV] = 1'b1;
          end else begin
            d.state = hdb_pkg::S_WAIT;
          end
        end
      end
      hdb_pkg::S_WAIT: begin
        // A half already begun never yields; only a fresh start does.
        if (q.second || !dsp_busy_i) begin
          d.dsp_addr = q.second ? q.addr + `HDB_HALF_STEP : q.addr;
          d.dsp_wdata = q.second ? q.wdata[31:16] : q.wdata[15:0];
          d.be = (q.size != `HDB_SZ_BYTE) ? 2'h3
               : (q.addr[0] ? 2'h2 : 2'h1);
          d.dsp_we = q.we;
          d.cnt = nf;
          d.tmo = tmo_ld;
          d.state = hdb_pkg::S_HIGH;
        end
      end
      hdb_pkg::S_HIGH: begin
        run = 1'b1;
        if (q.cnt == 4'h1) begin
          d.strobe_n = 1'b0;
          d.cnt = nf;
          d.state = hdb_pkg::S_LOW;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      hdb_pkg::S_LOW: begin
        run = 1'b1;
        if (q.cnt != 4'h1) begin
          d.cnt = q.cnt - 4'h1;
        end else if (dsp_tmo_err_i) begin
          fail = 1'b1;
          cause[`HDB_FL_DSP] = 1'b1;
        end else if (dsp_size_err_i) begin
          fail = 1'b1;
          cause[`HDB_FL_SIZE] = 1'b1;
        end else if (dsp_ready_i) begin
          run = 1'b0;
          d.strobe_n = 1'b1;
          if (q.size == `HDB_SZ_WORD && !q.second) begin
            d.second = 1'b1;
            d.rbuf = dsp_rdata_i;
            d.state = hdb_pkg::S_WAIT;
          end else begin
            if (!q.we)
              d.rdata = swap(rd_asm, q.ctrl[`HDB_CTL_BSW_RD],
                             q.ctrl[`HDB_CTL_HSW_RD], q.size);
            d.done[q.ini] = 1'b1;
            d.state = hdb_pkg::S_DONE;
          end
        end
      end
      hdb_pkg::S_DONE: d.state = hdb_pkg::S_IDLE;
      default: d.state = hdb_pkg::S_IDLE;
    endcase
    if (q.tmo_en && run && !fail) begin
      if (q.tmo == 9'h1) begin
        fail = 1'b1;
        cause[`HDB_FL_TMO] = 1'b1;
      end else begin
        d.tmo = q.tmo - 9'h1;
      end
    end
    if (fail) begin
      d.dbg_addr = fa;
      if (fw) d.dbg_data = fwv;
      else if (cause[`HDB_FL_SIZE]) d.dbg_data = rd_asm;
      d.dbg_flag = {fi, 1'b0, cause};
      d.err[fi] = 1'b1;
      d.done[fi] = 1'b1;
      d.strobe_n = 1'b1;
      d.state = hdb_pkg::S_DONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      q <= '{state: hdb_pkg::S_IDLE, ctrl: `HDB_CTL_RST,
             cfg_pend: `HDB_SIZE_RST, cfg_eff: `HDB_SIZE_RST,
             tgt: hdb_pkg::T_SNGL, strobe_n: 1'b1, default: '0};
    else
      q <= d;
  end

  assign reg_rdata_o     = q.reg_rdata;
  assign ini_done_o      = q.done;
  assign ini_err_o       = q.err;
  assign ini_rdata_o     = q.rdata;
  assign dsp_addr_o      = q.dsp_addr;
  assign dsp_wdata_o     = q.dsp_wdata;
  assign dsp_be_o        = q.be;
  assign dsp_we_o        = q.dsp_we;
  assign dsp_strobe_n_o  = q.strobe_n;
  assign dsp_resync_o    = q.resync;
  assign mem_host_only_o = mem_ho;
  assign per_host_only_o = per_ho;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_arb_grant_fixed: assert property (
    q.state == hdb_pkg::S_IDLE && ini_req_i == 3'h7 &&
    q.ctrl[`HDB_CTL_PRIO] == 2'h1 |=> q.ini == 2'h1)
    else $error("priority grant wrong");
  a_word_second_addr: assert property (
    $fell(dsp_strobe_n_o) && q.second |-> dsp_addr_o == q.addr + 24'h2)
    else $error("second half address wrong");
  a_excl_mem_err: assert property (
    q.state == hdb_pkg::S_IDLE && |ini_req_i && mem_ho &&
    arb_tgt == hdb_pkg::T_DUAL |=> q.state == hdb_pkg::S_DONE && |q.err)
    else $error("host-only dual RAM not refused");
  a_priv_err_flag: assert property (
    q.state == hdb_pkg::S_IDLE && |ini_req_i &&
    arb_tgt == hdb_pkg::T_PRPER |=> q.dbg_flag[`HDB_FL_PRIV] ##1
    q.state == hdb_pkg::S_IDLE)
    else $error("private peripheral not refused");
  a_tmo_abort_now: assert property (
    q.state == hdb_pkg::S_LOW && q.tmo_en && q.tmo == 9'h1 &&
    q.cnt == 4'h1 && !dsp_ready_i && !dsp_tmo_err_i && !dsp_size_err_i
    |=> |q.err && q.dbg_flag[`HDB_FL_TMO] && dsp_strobe_n_o)
    else $error("time-out abort missing");
  a_busy_hold_start: assert property (
    q.state == hdb_pkg::S_WAIT && !q.second && dsp_busy_i
    |=> q.state == hdb_pkg::S_WAIT && dsp_strobe_n_o)
    else $error("start despite DSP conflict");
  a_cfg_hold_run: assert property (
    dsp_rst_release_i ##1 dsp_rst_release_i |-> $stable(q.cfg_eff))
    else $error("size changed outside DSP reset");
  a_sa_deny_full: assert property (
    !mem_ho && q.cfg_eff == `HDB_SIZE_RST |-> dsp_sa_deny_o)
    else $error("shared full size not denied");
  a_strobe_low_len: assert property (
    $fell(dsp_strobe_n_o) && q.cnt == 4'h3 |=> !dsp_strobe_n_o ##1
    !dsp_strobe_n_o)
    else $error("strobe low phase too short");
endmodule // hdb_bridge

// ---- bench/hdb_dsp_model.sv ----
/*
 * DSP side model of the bridge port: a small RAM with a programmable answer
 * delay and error answers on command of the bench.
 * Assumes the bridge holds address and data stable while its strobe is low.
 */
`timescale 1ns/1ps
// ==========================================================================
// DSP port model
module hdb_dsp_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        strobe_n_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  delay_i,
  input  wire logic        tmo_i,
  input  wire logic        size_i,
  output logic      [15:0] rdata_o,
  output logic             ready_o,
  output logic             tmo_err_o,
  output logic             size_err_o
);
  // Byte enables are ignored, so only half-word data is kept exactly.
  logic [15:0] mem [0:255];
  logic [7:0]  lcnt_q;
  logic [15:0] held_q;
  // A slow target answers only after delay_i low cycles.
  assign ready_o    = !strobe_n_i && (lcnt_q >= delay_i);
  assign tmo_err_o  = ready_o && tmo_i;
  assign size_err_o = ready_o && size_i;
  // Released data lines toggle so that stale data cannot pass for a match.
  assign rdata_o    = ready_o ? mem[addr_i[8:1]] : ~held_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lcnt_q <= 8'h00;
      held_q <= 16'h0000;
    end else begin
      lcnt_q <= strobe_n_i ? 8'h00 : lcnt_q + 8'h01;
      held_q <= rdata_o;
      if (ready_o && we_i) begin
        mem[addr_i[8:1]] <= wdata_i;
      end
    end
  end
endmodule // hdb_dsp_model

// ---- bench/tb.sv ----
/*
 * Self-checking bench of the host shared access bridge.
 * Assumes the DSP model stands on the port and the bench drives the rest.
 */
`timescale 1ns/1ps
`include "hdb_defs.svh"
// ==========================================================================
// Bench
module tb;
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] raddr = 6'h00;
  logic [31:0] rwd = 32'h0, rrd, irdata;
  logic rwe = 1'b0, rre = 1'b0;
  logic [2:0] req = 3'h0, iwe = 3'h0, done, err, drop;
  logic [2:0][1:0] isz = '0;
  logic [2:0][23:0] iad = '0;
  logic [2:0][31:0] iwd = '0;
  logic rel = 1'b0, msh = 1'b1, psh = 1'b1, dbusy = 1'b0;
  logic [23:0] daddr, saaddr = 24'h0;
  logic [15:0] dwd, drd;
  logic [1:0] dbe;
  logic dwe, dstb_n, dres, drdy, dtmo, dsz, deny, mho, pho;
  logic [7:0] delay = 8'h00;
  logic ptmo = 1'b0, psz = 1'b0, last_res = 1'b0, prev_stb = 1'b1;
  logic [1:0] last_be = 2'h0;
  logic [31:0] rd;
  int bad_count = 0, total_checks = 0, falls = 0, low_len = 0;
  int last_low = 0, cyc = 0, got, fb;
  int ord [0:2];
  int first [0:3] = '{0, 1, 2, 0};
  int second [0:3] = '{1, 2, 0, 1};
  always #25 clk_i = ~clk_i;
  hdb_bridge dut (.clk_i(clk_i), .rst_n_i(rst_n), .reg_addr_i(raddr),
    .reg_wdata_i(rwd), .reg_we_i(rwe), .reg_re_i(rre), .reg_rdata_o(rrd),
    .ini_req_i(req), .ini_we_i(iwe), .ini_size_i(isz), .ini_addr_i(iad),
    .ini_wdata_i(iwd), .ini_done_o(done), .ini_err_o(err),
    .ini_rdata_o(irdata), .dsp_rst_release_i(rel), .mem_shared_i(msh),
    .per_shared_i(psh), .dsp_addr_o(daddr), .dsp_wdata_o(dwd),
    .dsp_be_o(dbe), .dsp_we_o(dwe), .dsp_strobe_n_o(dstb_n),
    .dsp_resync_o(dres), .dsp_rdata_i(drd), .dsp_ready_i(drdy),
    .dsp_busy_i(dbusy), .dsp_tmo_err_i(dtmo), .dsp_size_err_i(dsz),
    .dsp_sa_addr_i(saaddr), .dsp_sa_deny_o(deny), .mem_host_only_o(mho),
    .per_host_only_o(pho));
  hdb_dsp_model p (.clk_i(clk_i), .rst_n_i(rst_n), .strobe_n_i(dstb_n),
    .addr_i(daddr), .wdata_i(dwd), .we_i(dwe), .delay_i(delay),
    .tmo_i(ptmo), .size_i(psz), .rdata_o(drd), .ready_o(drdy),
    .tmo_err_o(dtmo), .size_err_o(dsz));
  // ========================================================================
  // Strobe monitor and hang guard
  always @(posedge clk_i) begin
    if (prev_stb && !dstb_n) begin
      falls++;
      last_res = dres;
      last_be = dbe;
    end
    if (!dstb_n) low_len++;
    else if (!prev_stb) begin
      last_low = low_len;
      low_len = 0;
    end
    prev_stb = dstb_n;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  // ========================================================================
  // Tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    raddr <= a;
    rwd <= d;
    rwe <= 1'b1;
    @(posedge clk_i);
    rwe <= 1'b0;
  endtask
  task automatic rdr(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk_i);
    raddr <= a;
    rre <= 1'b1;
    @(posedge clk_i);
    rre <= 1'b0;
    #1 chk(rrd, e);
  endtask
  task automatic deny_is(input logic [23:0] a, input logic e);
    @(posedge clk_i);
    saaddr <= a;
    #1 chk({31'h0, deny}, {31'h0, e});
  endtask
  task automatic acc(input int i, input logic w, input logic [1:0] s,
      input logic [23:0] a, input logic [31:0] d, input logic e, int nf);
    int f0;
    int n;
    f0 = falls;
    n = 0;
    @(posedge clk_i);
    req[i] <= 1'b1;
    iwe[i] <= w;
    isz[i] <= s;
    iad[i] <= a;
    iwd[i] <= d;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (done[i] !== 1'b1 && n < 400);
    rd = irdata;
    chk({31'h0, done[i]}, 32'h1);
    chk({31'h0, err[i]}, {31'h0, e});
    chk(falls - f0, nf);
    @(posedge clk_i);
    req[i] <= 1'b0;
    #1;
  endtask
  // ========================================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n <= 1'b1;
    rdr(`HDB_RA_CTRL, `HDB_CTL_RST);
    rdr(`HDB_RA_CFG, 32'h0000ffff);
    rdr(6'h3c, 32'h0);
    rdr(`HDB_RA_STAT, 32'h6);
    chk({30'h0, mho, pho}, 32'h3);
    deny_is(24'h004000, 1'b1);
    wr(`HDB_RA_CFG, 32'h2);
    deny_is(24'h003ffe, 1'b1);
    deny_is(24'h004000, 1'b0);
    acc(1, 1'b1, `HDB_SZ_HALF, 24'h000100, 32'h12345678, 1'b1, 0);
    rdr(`HDB_RA_DFLAG, 32'h48);
    rdr(`HDB_RA_DADDR, 32'h100);
    rdr(`HDB_RA_DDATA, 32'h12345678);
    wr(`HDB_RA_DFLAG, 32'h0);
    acc(0, 1'b0, `HDB_SZ_HALF, 24'hc00000, 32'h0, 1'b1, 0);
    rdr(`HDB_RA_DFLAG, 32'h10);
    wr(`HDB_RA_DFLAG, 32'h0);
    wr(`HDB_RA_CTRL, 32'h00000300);
    acc(0, 1'b1, `HDB_SZ_HALF, 24'h010000, 32'h1234, 1'b0, 1);
    chk(last_low, 3);
    chk({31'h0, last_res}, 32'h0);
    chk({16'h0, p.mem[0]}, 32'h1234);
    wr(`HDB_RA_CTRL, 32'h00040100);
    @(posedge clk_i);
    delay <= 8'd20;
    acc(2, 1'b0, `HDB_SZ_HALF, 24'h800010, 32'h0, 1'b1, 1);
    rdr(`HDB_RA_DFLAG, 32'h81);
    rdr(`HDB_RA_DADDR, 32'h800010);
    wr(`HDB_RA_DFLAG, 32'h0);
    wr(`HDB_RA_CTRL, 32'h00000100);
    acc(2, 1'b0, `HDB_SZ_HALF, 24'h800010, 32'h0, 1'b0, 1);
    @(posedge clk_i);
    rel <= 1'b1;
    msh <= 1'b0;
    psh <= 1'b0;
    #1 chk({30'h0, mho, pho}, 32'h3);
    deny_is(24'h004000, 1'b0);
    wr(`HDB_RA_CFG, 32'hffff);
    deny_is(24'h004000, 1'b0);
    @(posedge clk_i);
    psh <= 1'b1;
    msh <= 1'b1;
    #1 chk({30'h0, mho, pho}, 32'h0);
    deny_is(24'h000000, 1'b0);
    wr(`HDB_RA_CTRL, 32'h00040100);
    acc(0, 1'b0, `HDB_SZ_HALF, 24'h800010, 32'h0, 1'b0, 1);
    @(posedge clk_i);
    delay <= 8'd0;
    ptmo <= 1'b1;
    acc(0, 1'b0, `HDB_SZ_HALF, 24'h800010, 32'h0, 1'b1, 1);
    rdr(`HDB_RA_DFLAG, 32'h02);
    wr(`HDB_RA_DFLAG, 32'h0);
    @(posedge clk_i);
    ptmo <= 1'b0;
    psz <= 1'b1;
    acc(1, 1'b1, `HDB_SZ_HALF, 24'h800030, 32'hbeef, 1'b1, 1);
    rdr(`HDB_RA_DFLAG, 32'h44);
    rdr(`HDB_RA_DADDR, 32'h800030);
    rdr(`HDB_RA_DDATA, 32'hbeef);
    @(posedge clk_i);
    psz <= 1'b0;
    wr(`HDB_RA_CTRL, 32'h00000104);
    acc(0, 1'b1, `HDB_SZ_WORD, 24'h000010, 32'haabbccdd, 1'b0, 2);
    chk({31'h0, last_res}, 32'h1);
    chk({16'h0, p.mem[8]}, 32'hbbaa);
    chk({16'h0, p.mem[9]}, 32'hddcc);
    acc(1, 1'b0, `HDB_SZ_WORD, 24'h000010, 32'h0, 1'b0, 2);
    chk(rd, 32'hddccbbaa);
    wr(`HDB_RA_CTRL, 32'h00000120);
    acc(1, 1'b0, `HDB_SZ_WORD, 24'h000010, 32'h0, 1'b0, 2);
    chk(rd, 32'hbbaaddcc);
    wr(`HDB_RA_CTRL, 32'h00000108);
    acc(2, 1'b1, `HDB_SZ_HALF, 24'h000020, 32'h0011, 1'b0, 1);
    chk({16'h0, p.mem[16]}, 32'h0011);
    wr(`HDB_RA_CTRL, 32'h00000104);
    acc(2, 1'b1, `HDB_SZ_HALF, 24'h000020, 32'h0011, 1'b0, 1);
    chk({16'h0, p.mem[16]}, 32'h1100);
    acc(0, 1'b1, `HDB_SZ_BYTE, 24'h000051, 32'hab, 1'b0, 1);
    chk({30'h0, last_be}, 32'h2);
    chk({16'h0, p.mem[40]}, 32'habab);
    @(posedge clk_i);
    psz <= 1'b1;
    acc(1, 1'b0, `HDB_SZ_HALF, 24'h800010, 32'h0, 1'b1, 1);
    rdr(`HDB_RA_DDATA, 32'hbbaa);
    @(posedge clk_i);
    psz <= 1'b0;
    @(posedge clk_i);
    dbusy <= 1'b1;
    fb = falls;
    fork
      acc(0, 1'b1, `HDB_SZ_HALF, 24'h000060, 32'h7777, 1'b0, 1);
      begin
        repeat (12) @(posedge clk_i);
        #1 chk(falls - fb, 0);
        @(posedge clk_i);
        dbusy <= 1'b0;
      end
    join
    for (int k = 0; k < 4; k++) begin
      wr(`HDB_RA_CTRL, 32'h00000100 | k);
      @(posedge clk_i);
      for (int j = 0; j < 3; j++) begin
        iwe[j] <= 1'b1;
        isz[j] <= `HDB_SZ_HALF;
        iad[j] <= 24'(32'h40 + j * 2);
        iwd[j] <= 32'(j);
      end
      req <= 3'h7;
      got = 0;
      drop = 3'h0;
      for (int c = 0; c < 300 && got < 3; c++) begin
        @(posedge clk_i);
        req <= req & ~drop;
        #1;
        for (int j = 0; j < 3; j++) begin
          if (done[j] === 1'b1) begin
            ord[got] = j;
            got++;
            drop[j] = 1'b1;
          end
        end
      end
      @(posedge clk_i);
      req <= 3'h0;
      chk(ord[0], first[k]);
      chk(ord[1], second[k]);
    end
    @(posedge clk_i);
    rel <= 1'b0;
    @(posedge clk_i);
    rel <= 1'b1;
    deny_is(24'h004000, 1'b1);
    finish_test();
  end
endmodule // tb
